// ### inc/ssrr_pkg.sv
package ssrr_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 25;
  localparam int BIT_US = 950;
  localparam int HALF_BIT_US = 475;
  localparam int STOP5_US = 2900;
  localparam int STOPU_US = 950;
  localparam int BIT_CYC = BIT_US * CLK_MHZ;
  localparam int HALF_CYC = HALF_BIT_US * CLK_MHZ;
  localparam int STOP5_CYC = STOP5_US * CLK_MHZ;
  localparam int STOPU_CYC = STOPU_US * CLK_MHZ;
  localparam int CW = 17;
  localparam int BW = 16;

  // Character shape
  localparam int DW = 8;
  localparam int MIN_BITS = 5;
  localparam int MKW = 9;
  localparam logic MARK = 1'b1;

  // Character history memory
  localparam int HD = 8;
  localparam int HAW = 3;

  // Register byte offsets
  localparam int AW = 6;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_BAUD = 6'h04;
  localparam logic [5:0] OFF_STAT = 6'h08;
  localparam logic [5:0] OFF_LAST = 6'h0C;
  localparam logic [5:0] OFF_HIST = 6'h20;

  // Control fields
  localparam int CTRL_TEST = 0;
  localparam int CTRL_UNIV = 1;
  localparam int CTRL_LEN = 2;
  localparam logic [1:0] LEN_RST = 2'h3;

  // Status fields
  localparam int ST_SYNC = 0;
  localparam int ST_CTRL = 1;
  localparam int ST_STOP = 2;
  localparam int ST_MOTOR = 3;
  localparam int ST_CARR = 4;
  localparam int ST_LATE = 5;
  localparam int ST_PTR = 8;

  // Receive phase, Gray order
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_DELAY = 2'h1,
    PH_RUN = 2'h3,
    PH_STOP = 2'h2
  } ssrr_phase_type;
endpackage

// ### core/ssrr_char_mem.sv
`timescale 1ns/1ps
module ssrr_char_mem (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [ssrr_pkg::HAW-1:0] wr_addr_in,
  input wire logic [ssrr_pkg::DW-1:0] wr_data_in,
  // Read port
  input wire logic [ssrr_pkg::HAW-1:0] rd_addr_in,
  output logic [ssrr_pkg::DW-1:0] rd_data_out
);
  typedef struct packed {
    logic [ssrr_pkg::HD-1:0][ssrr_pkg::DW-1:0] mem;
    logic [ssrr_pkg::DW-1:0] rd;
  } ssrr_mem_state_type;

  ssrr_mem_state_type m_q;
  ssrr_mem_state_type m_d;

  always_comb begin
    m_d = m_q;
    if (ce_in) begin
      m_d.rd = m_q.mem[rd_addr_in];
      if (wr_en_in) begin
        m_d.mem[wr_addr_in] = wr_data_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign rd_data_out = m_q.rd;
endmodule

// ### core/ssrr_receiver.sv
`timescale 1ns/1ps
// What this block does
// (RULE1) Motor run follows the modem data-mode interlock, dropping at disconnect.
// (RULE2) Without carrier the received input is forced to MARK.
// (RULE3) With carrier the real line signal reaches the receiver.
// (RULE4) A start transition runs a half-bit delay before the start pulse.
// (RULE5) Start pulse sets the control flop; oscillator then advances once per bit.
// (RULE6) Advances shift marker and data; marker at last stage primes the clear.
// (RULE7) Clearing the control flop stops the oscillator and fires the stop one-shot.
// (RULE8) Stop one-shot length is 2.9 ms or 0.95 ms by configuration.
// (RULE9) Firing the stop one-shot clears the sync flop.
// (RULE10) With sync clear the gate holds idle until the line is seen at MARK outside the stop interval, or sync set.
// (RULE11) Stop end sets the sync flop only when the line is at MARK.
// (RULE12) SPACE at stop end leaves the sync flop as it was.
// (RULE13) An enabled MARK-to-SPACE edge starts a character only from idle, never mid-character.
// (RULE14) Repeated deferral slides the start later until alignment returns.
// (RULE15) In operate mode the sync flop enables the signal gate.
// (RULE16) Reset sets the control flop and runs one cycle to clear sync.
// (RULE17) Test mode forces open line and gates from the stop one-shot.
// (RULE18) Data bits five to eight and bit period are configurable.
// (RULE19) All one-shots are counters on the system clock.
module ssrr_receiver #(
  parameter logic [15:0] BIT_CYC_DEF = 16'(ssrr_pkg::BIT_CYC),
  parameter logic [16:0] STOP5_CYC = 17'(ssrr_pkg::STOP5_CYC),
  parameter logic [16:0] STOPU_CYC = 17'(ssrr_pkg::STOPU_CYC)
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Avalon-MM slave
  input wire logic [ssrr_pkg::AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Modem side
  input wire logic line_in,
  input wire logic carrier_in,
  input wire logic interlock_in,
  // Receiver outputs
  output logic motor_run_out,
  output logic signal_gate_out,
  output logic sync_flop_out,
  output logic char_valid_out,
  output logic [ssrr_pkg::DW-1:0] char_data_out
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    ssrr_pkg::ssrr_phase_type ph;
    logic [ssrr_pkg::CW-1:0] cnt;
    logic [ssrr_pkg::MKW-1:0] mk;
    logic [ssrr_pkg::DW-1:0] sh;
    logic pwr;
    logic sync;
    logic arm;
    logic prev;
    logic late;
    logic motor;
    logic ack;
    logic rsel;
    logic test;
    logic univ;
    logic [1:0] len;
    logic [ssrr_pkg::BW-1:0] baud;
    logic [31:0] rdata;
    logic [ssrr_pkg::DW-1:0] last;
    logic [ssrr_pkg::HAW-1:0] wptr;
    logic cval;
  } ssrr_state_type;

  ssrr_state_type q;
  ssrr_state_type n;

  logic line_eff;
  logic gate_block;
  logic gate;
  logic fall;
  logic adv;
  logic prime;
  logic req;
  logic [3:0] nbits;
  logic [ssrr_pkg::CW-1:0] half_cnt;
  logic [ssrr_pkg::CW-1:0] bit_cnt;
  logic [ssrr_pkg::CW-1:0] stop_len;
  logic [ssrr_pkg::DW-1:0] mem_rd;
  logic late_ev;
  logic [31:0] ctl_new;
  logic [31:0] baud_new;

  // Register offset match
  function automatic logic hit(input logic [ssrr_pkg::AW-1:0] a,
                               input logic [ssrr_pkg::AW-1:0] off);
    hit = (a[ssrr_pkg::AW-1:2] == off[ssrr_pkg::AW-1:2]);
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // Status word
  function automatic logic [31:0] status(input ssrr_state_type s);
    logic [31:0] r;
    r = 32'h0;
    r[ssrr_pkg::ST_SYNC] = s.sync;
    r[ssrr_pkg::ST_CTRL] = (s.ph == ssrr_pkg::PH_RUN);
    r[ssrr_pkg::ST_STOP] = (s.ph == ssrr_pkg::PH_STOP);
    r[ssrr_pkg::ST_MOTOR] = s.motor;
    r[ssrr_pkg::ST_CARR] = s.s2[1];
    r[ssrr_pkg::ST_LATE] = s.late;
    r[ssrr_pkg::ST_PTR +: ssrr_pkg::HAW] = s.wptr;
    status = r;
  endfunction

  ssrr_char_mem u_mem (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .wr_en_in(q.cval),
    .wr_addr_in(q.wptr),
    .wr_data_in(q.last),
    .rd_addr_in(avs_address_in[ssrr_pkg::HAW+1:2]),
    .rd_data_out(mem_rd)
  );

  always_comb begin
    n = q;
    nbits = 4'(ssrr_pkg::MIN_BITS) + {2'h0, q.len}; // RULE18
    half_cnt = {2'h0, q.baud[ssrr_pkg::BW-1:1]} - 17'h1; // RULE4 RULE19
    bit_cnt = {1'b0, q.baud} - 17'h1; // RULE18 RULE19
    stop_len = (q.univ ? STOPU_CYC : STOP5_CYC) - 17'h1; // RULE8 RULE19
    line_eff = ssrr_pkg::MARK; // RULE2
    if (q.s2[1]) begin
      line_eff = q.test ? !ssrr_pkg::MARK : q.s2[0]; // RULE3 RULE17
    end
    // Test holds the line open, so blank characters repeat
    gate_block = q.test ? (q.ph == ssrr_pkg::PH_STOP) // RULE17
                        : (!q.sync && !q.arm); // RULE10 RULE15
    gate = gate_block ? ssrr_pkg::MARK : line_eff;
    fall = q.prev && !gate; // RULE13
    adv = (q.ph == ssrr_pkg::PH_RUN) && (q.cnt == 17'h0); // RULE5
    prime = q.mk[nbits]; // RULE6
    req = avs_read_in || avs_write_in;
    late_ev = q.ph == ssrr_pkg::PH_STOP && q.cnt == 17'h0 && !q.test
              && line_eff != ssrr_pkg::MARK;
    ctl_new = merge({28'h0, q.len, q.univ, q.test}, avs_writedata_in, avs_byteenable_in);
    baud_new = merge({16'h0, q.baud}, avs_writedata_in, avs_byteenable_in);
    if (ce_in) begin
      n.s1 = {interlock_in, carrier_in, line_in};
      n.s2 = q.s1;
      n.motor = q.s2[2]; // RULE1
      n.prev = gate;
      n.cval = 1'b0;
      if (q.cval) begin
        n.wptr = q.wptr + 3'h1;
      end
      if (!q.sync && q.ph != ssrr_pkg::PH_STOP && line_eff == ssrr_pkg::MARK) begin
        n.arm = 1'b1; // RULE10 RULE14
      end
      case (q.ph)
        ssrr_pkg::PH_IDLE: begin
          if (fall) begin
            n.ph = ssrr_pkg::PH_DELAY; // RULE4 RULE13
            n.cnt = half_cnt;
          end
        end
        ssrr_pkg::PH_DELAY: begin
          if (q.cnt == 17'h0) begin
            n.ph = ssrr_pkg::PH_RUN; // RULE5
            n.cnt = bit_cnt;
            n.mk = 9'h001;
            n.sh = 8'h00;
          end else begin
            n.cnt = q.cnt - 17'h1;
          end
        end
        ssrr_pkg::PH_RUN: begin
          if (!adv) begin
            n.cnt = q.cnt - 17'h1;
          end else if (q.pwr || prime) begin
            n.ph = ssrr_pkg::PH_STOP; // RULE7 RULE16
            n.cnt = stop_len;
            n.pwr = 1'b0;
            n.sync = 1'b0; // RULE9
            n.arm = 1'b0;
            if (!q.pwr) begin
              n.cval = 1'b1;
              n.last = q.sh >> (4'(ssrr_pkg::DW) - nbits);
            end
          end else begin
            n.cnt = bit_cnt;
            n.mk = q.mk << 1; // RULE6
            n.sh = {line_eff, q.sh[ssrr_pkg::DW-1:1]};
          end
        end
        ssrr_pkg::PH_STOP: begin
          if (q.cnt != 17'h0) begin
            n.cnt = q.cnt - 17'h1;
          end else begin
            n.ph = ssrr_pkg::PH_IDLE;
            if (!q.test && line_eff == ssrr_pkg::MARK) begin
              n.sync = 1'b1; // RULE11
            end else if (!q.test) begin
              n.late = 1'b1; // RULE12 RULE14
            end
          end
        end
        default: begin
          n.ph = ssrr_pkg::PH_IDLE;
        end
      endcase
      // Bus slave, one wait state
      if (req && !q.ack) begin
        n.ack = 1'b1;
        n.rsel = hit(avs_address_in, ssrr_pkg::OFF_HIST)
              || avs_address_in[ssrr_pkg::AW-1];
        n.rdata = 32'h0;
        if (hit(avs_address_in, ssrr_pkg::OFF_CTRL)) begin
          n.rdata[ssrr_pkg::CTRL_TEST] = q.test;
          n.rdata[ssrr_pkg::CTRL_UNIV] = q.univ;
          n.rdata[ssrr_pkg::CTRL_LEN +: 2] = q.len;
        end else if (hit(avs_address_in, ssrr_pkg::OFF_BAUD)) begin
          n.rdata[ssrr_pkg::BW-1:0] = q.baud;
        end else if (hit(avs_address_in, ssrr_pkg::OFF_STAT)) begin
          n.rdata = status(q);
        end else if (hit(avs_address_in, ssrr_pkg::OFF_LAST)) begin
          n.rdata[ssrr_pkg::DW-1:0] = q.last;
        end
      end else if (q.ack) begin
        n.ack = 1'b0;
        if (avs_write_in && hit(avs_address_in, ssrr_pkg::OFF_CTRL)) begin
          n.test = ctl_new[ssrr_pkg::CTRL_TEST];
          n.univ = ctl_new[ssrr_pkg::CTRL_UNIV];
          n.len = ctl_new[ssrr_pkg::CTRL_LEN +: 2];
        end
        if (avs_write_in && hit(avs_address_in, ssrr_pkg::OFF_BAUD)) begin
          n.baud = baud_new[ssrr_pkg::BW-1:0];
        end
        // Set wins over clear
        if (avs_write_in && hit(avs_address_in, ssrr_pkg::OFF_STAT)
            && avs_byteenable_in[0] && avs_writedata_in[ssrr_pkg::ST_LATE]
            && !late_ev) begin
          n.late = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.ph <= ssrr_pkg::PH_RUN; // RULE16
      q.pwr <= 1'b1;
      q.cnt <= {1'b0, BIT_CYC_DEF} - 17'h1; // RULE16
      q.prev <= ssrr_pkg::MARK;
      q.s1 <= 3'h1;
      q.s2 <= 3'h1;
      q.len <= ssrr_pkg::LEN_RST;
      q.baud <= BIT_CYC_DEF;
    end else begin
      q <= n;
    end
  end

  assign avs_waitrequest_out = req && !(q.ack && ce_in);
  assign avs_readdata_out = q.rsel ? {24'h0, mem_rd} : q.rdata;
  assign motor_run_out = q.motor;
  assign signal_gate_out = q.prev;
  assign sync_flop_out = q.sync;
  assign char_valid_out = q.cval;
  assign char_data_out = q.last;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_start_taken;
    ce_in && q.ph == ssrr_pkg::PH_IDLE && fall;
  endsequence
  sequence s_char_end;
    ce_in && adv && prime && !q.pwr;
  endsequence
  sequence s_stopped;
    q.ph == ssrr_pkg::PH_STOP && !q.sync && q.cval;
  endsequence

  property p_motor;
    ce_in && q.s2[2] |=> motor_run_out;
  endproperty
  a_motor: assert property (p_motor) else $error("motor not run"); // RULE1

  property p_blank;
    !q.s2[1] |-> line_eff == ssrr_pkg::MARK;
  endproperty
  a_blank: assert property (p_blank) else $error("line not blanked"); // RULE2

  property p_pass;
    q.s2[1] && !q.test |-> line_eff == q.s2[0];
  endproperty
  a_pass: assert property (p_pass) else $error("line not passed"); // RULE3

  property p_delay;
    s_start_taken |=> q.ph == ssrr_pkg::PH_DELAY && q.cnt == $past(half_cnt);
  endproperty
  a_delay: assert property (p_delay) else $error("half delay wrong"); // RULE4

  property p_run;
    ce_in && q.ph == ssrr_pkg::PH_DELAY && q.cnt == 17'h0
      |=> q.ph == ssrr_pkg::PH_RUN && q.mk == 9'h001;
  endproperty
  a_run: assert property (p_run) else $error("start pulse missing"); // RULE5

  property p_char_end;
    s_char_end |=> s_stopped;
  endproperty
  a_char_end: assert property (p_char_end) else $error("no stop after char"); // RULE7

  property p_sync_set;
    ce_in && q.ph == ssrr_pkg::PH_STOP && q.cnt == 17'h0 && line_eff && !q.test
      |=> q.sync && q.ph == ssrr_pkg::PH_IDLE;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync not set"); // RULE11

  property p_sync_hold;
    ce_in && q.ph == ssrr_pkg::PH_STOP && q.cnt == 17'h0 && !line_eff && !q.test
      |=> !q.sync && q.late;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync changed on space"); // RULE12

  property p_gate;
    !q.test && !q.sync && !q.arm |=> signal_gate_out == ssrr_pkg::MARK || !$past(ce_in);
  endproperty
  a_gate: assert property (p_gate) else $error("gate not idle"); // RULE10
endmodule

// ### bench/ssrr_modem_model.sv
`timescale 1ns/1ps
module ssrr_modem_model (
  // Clock
  input wire logic ref_clk_in,
  // Data set outputs
  output logic line_out,
  output logic carrier_out,
  output logic interlock_out
);
  logic line_q = 1'b1;
  logic released_q = 1'b0;
  logic noise_q = 1'b0;
  logic carrier_q = 1'b1;
  logic interlock_q = 1'b0;

  // Released line shows a changing pattern
  always @(posedge ref_clk_in) begin
    noise_q <= ~noise_q;
  end
  assign line_out = released_q ? noise_q : line_q;
  assign carrier_out = carrier_q;
  assign interlock_out = interlock_q;

  task automatic set_interlock(input logic v);
    @(posedge ref_clk_in);
    interlock_q <= v;
  endtask

  task automatic set_line(input logic v);
    @(posedge ref_clk_in);
    line_q <= v;
  endtask

  // Line is valid for 8 cycles before carrier rises and for 8 cycles after it falls
  task automatic set_carrier(input logic v);
    @(posedge ref_clk_in);
    if (v) begin
      released_q <= 1'b0;
      line_q <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      carrier_q <= 1'b1;
    end else begin
      carrier_q <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
      released_q <= 1'b1;
    end
  endtask

  // Start bit, data LSB first, one stop bit, then tail level
  task automatic send_char(input logic [7:0] d, input int n, input int b, input logic tail);
    @(posedge ref_clk_in);
    line_q <= 1'b0;
    repeat (b) @(posedge ref_clk_in);
    for (int i = 0; i < n; i++) begin
      line_q <= d[i];
      repeat (b) @(posedge ref_clk_in);
    end
    line_q <= 1'b1;
    repeat (b) @(posedge ref_clk_in);
    line_q <= tail;
  endtask
endmodule

// ### bench/tb_start_stop_receive_resync.sv
`timescale 1ns/1ps
module tb_start_stop_receive_resync;
  // Bench signals
  logic ref_clk_in, rst_in, ce, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_byteenable, be_sel;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic line, carrier, interlock, motor, gate, sync, valid;
  logic [7:0] cdata;
  int fail_count, checks, n;
  typedef struct packed {
    logic [1:0] len;
    logic univ;
    logic [15:0] baud;
    logic [7:0] data;
    logic [7:0] exp;
  } ssrr_row_type;
  ssrr_row_type rows [6] = '{'{2'h0, 1'b0, 16'h0028, 8'hB5, 8'h15},
    '{2'h1, 1'b1, 16'h0028, 8'hCA, 8'h0A}, '{2'h2, 1'b0, 16'h003C, 8'hD3, 8'h53},
    '{2'h3, 1'b1, 16'h0028, 8'hA5, 8'hA5}, '{2'h3, 1'b0, 16'h0028, 8'h01, 8'h01},
    '{2'h0, 1'b1, 16'h0032, 8'h1F, 8'h1F}};

  ssrr_receiver #(.BIT_CYC_DEF(16'h0028), .STOP5_CYC(17'h00064), .STOPU_CYC(17'h00028))
  ssrr_receiver_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
    .line_in(line), .carrier_in(carrier), .interlock_in(interlock),
    .motor_run_out(motor), .signal_gate_out(gate), .sync_flop_out(sync),
    .char_valid_out(valid), .char_data_out(cdata));
  ssrr_modem_model ssrr_modem_model_inst (.ref_clk_in(ref_clk_in), .line_out(line),
    .carrier_out(carrier), .interlock_out(interlock));

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic settle(input int c);
    repeat (c) @(negedge ref_clk_in);
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] wd);
    @(posedge ref_clk_in);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be_sel;
    avs_read <= ~we;
    avs_write <= we;
    do begin
      @(negedge ref_clk_in);
      rd = avs_readdata;
    end while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk_in);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check32(rd, exp);
  endtask

  // Configure, send one character, time the answer and the stop interval
  task automatic run_row(input ssrr_row_type r, input logic tail);
    int b, s, stop, lat, base;
    b = r.baud;
    stop = r.univ ? 40 : 100;
    base = b / 2 + b * (6 + r.len);
    bus(1'b1, 6'h00, {28'h0, r.len, r.univ, 1'b0});
    bus(1'b1, 6'h04, {16'h0, r.baud});
    fork
      ssrr_modem_model_inst.send_char(r.data, 5 + r.len, b, tail);
      begin
        lat = 0;
        do begin
          @(negedge ref_clk_in);
          lat++;
        end while (valid !== 1'b1 && lat < 3000);
        check32({24'h0, cdata}, {24'h0, r.exp});
        check32({31'h0, sync}, 32'h0);
        check32(32'(lat >= base && lat <= base + 12), 32'h1);
        s = 0;
        while (tail && sync !== 1'b1 && s < 500) begin
          @(negedge ref_clk_in);
          s++;
        end
        if (tail) check32(32'(s >= stop - 4 && s <= stop + 4), 32'h1);
      end
    join
    $display("test row done");
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk_in);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst_in = 1'b1;
    ce = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    be_sel = 4'hF;
    repeat (3) @(posedge ref_clk_in);
    check32({28'h0, gate, sync, motor, valid}, 32'h8);
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    ce <= 1'b0;
    settle(30);
    check32({31'h0, sync}, 32'h0);
    settle(70);
    @(posedge ref_clk_in);
    ce <= 1'b1;
    settle(120);
    check32({31'h0, sync}, 32'h0);
    settle(60);
    check32({31'h0, sync}, 32'h1);
    rd_chk(6'h00, 32'h0000000C);
    rd_chk(6'h04, 32'h00000028);
    be_sel = 4'h1;
    bus(1'b1, 6'h04, 32'h0000FF33);
    be_sel = 4'hF;
    rd_chk(6'h04, 32'h00000033);
    bus(1'b1, 6'h10, 32'hFFFFFFFF);
    rd_chk(6'h10, 32'h0);
    $display("test reset done");
    ssrr_modem_model_inst.set_interlock(1'b1);
    settle(6);
    check32({31'h0, motor}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      run_row(rows[i], 1'b1);
      rd_chk(6'h0C, {24'h0, rows[i].exp});
    end
    // SPACE at stop end defers start
    run_row(rows[0], 1'b0);
    settle(150);
    check32({30'h0, gate, sync}, 32'h2);
    rd_chk(6'h08, 32'h00000738);
    check32({31'h0, rd[5]}, 32'h1);
    ssrr_modem_model_inst.set_line(1'b1);
    settle(10);
    bus(1'b1, 6'h08, 32'h00000020);
    rd_chk(6'h08, 32'h00000718);
    check32({31'h0, rd[5]}, 32'h0);
    run_row(rows[0], 1'b1);
    $display("test deferral done");
    // Test mode regenerates blank characters
    bus(1'b1, 6'h00, 32'h00000001);
    n = 0;
    while (valid !== 1'b1 && n < 1500) begin
      @(negedge ref_clk_in);
      n++;
    end
    check32({23'h0, sync, cdata}, 32'h0);
    bus(1'b1, 6'h00, 32'h0000000C);
    settle(500);
    $display("test test_mode done");
    ssrr_modem_model_inst.set_carrier(1'b0);
    n = 0;
    repeat (300) begin
      @(negedge ref_clk_in);
      if (gate !== 1'b1 || valid === 1'b1) n++;
    end
    check32(32'(n), 32'h0);
    ssrr_modem_model_inst.set_carrier(1'b1);
    settle(20);
    run_row(rows[1], 1'b1);
    ssrr_modem_model_inst.set_interlock(1'b0);
    settle(6);
    check32({31'h0, motor}, 32'h0);
    $display("test modem done");
    tally_and_finish();
  end
endmodule
